// ---- mrf_pkg.sv ----
// Package of constants and carrier types for the Modbus RTU frame logic
package mrf_pkg;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam int CRC_SHIFTS = 8;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
	localparam logic [2:0] EXC_LEN = 3'h5;

	// Transmit sequencer states
	typedef enum logic [2:0] {
		MRF_IDLE = 3'b000,
		MRF_EXC = 3'b001,
		MRF_FLOAT = 3'b010,
		MRF_CRC_LO = 3'b011,
		MRF_CRC_HI = 3'b100
	} mrf_state_t;

	// Why a request was refused
	typedef struct packed {
		logic bad_addr;
		logic bad_value;
		logic dev_fail;
	} mrf_fault_t;

	// Outgoing byte stream
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} mrf_byte_t;

	// Whole state of the framer
	typedef struct packed {
		mrf_state_t state;
		logic [15:0] tx_crc;
		logic [15:0] rx_crc;
		logic [7:0] rx_prev;
		logic [7:0] rx_prev2;
		logic [1:0] rx_cnt;
		logic crc_err;
		logic crc_ok;
		logic [7:0] exc_code;
		logic [7:0] func;
		logic [31:0] shift;
		logic [2:0] idx;
		mrf_byte_t tx;
	} mrf_regs_t;
endpackage

// ---- mrf_framer.sv ----
// Modbus RTU exception framer, float byte order and CRC generate/check
//
// Notes on behaviour
// R1: Exception reply carries function code plus 80 hex, then one code byte.
// R2: Code 1 when the function code is not accepted.
// R3: Code 2 when the query address is not permitted.
// R4: Code 3 when a field value, implied length or count is illegal.
// R5: Code 4 for any other refusal, such as a write out of limits.
// R6: Multi-byte quantities go most significant byte first by default.
// R7: Default float: register N holds bits 31..16, register N+1 bits 15..0.
// R8: A configurable alternative float byte order is supported.
// R9: Sender computes a 16-bit CRC and appends it as two bytes.
// R10: Receiver recomputes CRC over the frame and flags any mismatch.
// R11: CRC accumulator presets to all ones at each message start.
// R12: Each byte is XORed into the accumulator low byte before shifting.
// R13: Eight right shifts per byte, XOR with A001 when a one drops out.
// R14: Accumulator after the last byte is the frame CRC.
// R15: CRC sent low byte first, then high byte.
// R16: Only function codes 3, 8 and 16 are accepted.
// R17: Exception frame is address, modified function, code, then two CRC bytes.
`timescale 1ns/1ns
module mrf_framer (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] SLAVE_ADDR_IN,
	input wire logic RX_START_IN,
	input wire logic RX_VALID_IN,
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_END_IN,
	input wire logic REQ_IN,
	input wire logic [7:0] REQ_FUNC_IN,
	input wire mrf_pkg::mrf_fault_t REQ_FAULT_IN,
	input wire logic FLOAT_IN,
	input wire logic [31:0] FLOAT_DATA_IN,
	input wire logic FLOAT_SWAP_IN,
	input wire logic TX_READY_IN,
	output logic BUSY_OUT,
	output logic TX_VALID_OUT,
	output logic [7:0] TX_DATA_OUT,
	output logic TX_LAST_OUT,
	output logic [7:0] EXC_CODE_OUT,
	output logic CRC_ERR_OUT,
	output logic CRC_OK_OUT
);
	mrf_pkg::mrf_regs_t r_reg;
	mrf_pkg::mrf_regs_t r_next;
	logic [7:0] next_byte;
	logic byte_taken;

	// One byte through the CRC: XOR low byte, then eight shifts
	function automatic logic [15:0] crc_byte(input logic [15:0] acc, input logic [7:0] b);
		logic [15:0] c;
		c = acc ^ {8'h00, b}; // R12
		for (int i = 0; i < mrf_pkg::CRC_SHIFTS; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ mrf_pkg::CRC_POLY; // R13
			end else begin
				c = c >> 1; // R13
			end
		end
		return c;
	endfunction

	// Picks the next float byte; swap flips words and bytes for the alternate order
	function automatic logic [7:0] float_byte(input logic [31:0] f, input logic [2:0] k,
		input logic swap);
		logic [1:0] j;
		j = swap ? k[1:0] : ~k[1:0]; // R8
		return f[{j, 3'b000} +: 8]; // R6 R7
	endfunction

	assign byte_taken = r_reg.tx.valid && TX_READY_IN;

	// Next state of the whole framer
	always_comb begin
		r_next = r_reg;
		next_byte = 8'h00;
		r_next.crc_ok = 1'b0;
		// Receive side checker
		if (RX_START_IN) begin
			r_next.rx_crc = mrf_pkg::CRC_PRESET; // R11
			r_next.rx_cnt = 2'h0;
			r_next.crc_err = 1'b0;
		end else if (RX_VALID_IN) begin
			// The last two bytes are the CRC itself, so they are held back two deep
			if (r_reg.rx_cnt == 2'h2) begin
				r_next.rx_crc = crc_byte(r_reg.rx_crc, r_reg.rx_prev2); // R10
			end else begin
				r_next.rx_cnt = r_reg.rx_cnt + 2'h1;
			end
			r_next.rx_prev2 = r_reg.rx_prev;
			r_next.rx_prev = RX_DATA_IN;
		end else if (RX_END_IN) begin
			// Received field arrives low byte then high byte
			if (r_reg.rx_cnt != 2'h2 || r_reg.rx_crc != {r_reg.rx_prev, r_reg.rx_prev2}) begin
				r_next.crc_err = 1'b1; // R10 R14 R15
			end else begin
				r_next.crc_ok = 1'b1;
			end
		end
		// Transmit sequencer
		if (byte_taken) begin
			r_next.tx.valid = 1'b0;
			r_next.tx.last = 1'b0;
			r_next.tx_crc = crc_byte(r_reg.tx_crc, r_reg.tx.data); // R9
			r_next.idx = r_reg.idx + 3'h1;
		end
		unique case (r_reg.state)
			mrf_pkg::MRF_IDLE: begin
				if (REQ_IN) begin
					r_next.tx_crc = mrf_pkg::CRC_PRESET; // R11
					r_next.idx = 3'h0;
					r_next.func = REQ_FUNC_IN;
					r_next.state = mrf_pkg::MRF_EXC;
					// Function check outranks field faults
					if (REQ_FUNC_IN != mrf_pkg::FC_READ_HOLD && REQ_FUNC_IN != mrf_pkg::FC_DIAG
						&& REQ_FUNC_IN != mrf_pkg::FC_WRITE_MULTI) begin
						r_next.exc_code = mrf_pkg::EXC_ILLEGAL_FUNC; // R2 R16
					end else if (REQ_FAULT_IN.bad_addr) begin
						r_next.exc_code = mrf_pkg::EXC_ILLEGAL_ADDR; // R3
					end else if (REQ_FAULT_IN.bad_value) begin
						r_next.exc_code = mrf_pkg::EXC_ILLEGAL_VALUE; // R4
					end else begin
						r_next.exc_code = mrf_pkg::EXC_DEVICE_FAIL; // R5
					end
				end else if (FLOAT_IN) begin
					r_next.tx_crc = mrf_pkg::CRC_PRESET; // R11
					r_next.idx = 3'h0;
					r_next.shift = FLOAT_DATA_IN;
					r_next.state = mrf_pkg::MRF_FLOAT;
				end
			end
			mrf_pkg::MRF_EXC: begin
				if (!r_reg.tx.valid && !byte_taken) begin
					unique case (r_reg.idx)
						3'h0: next_byte = SLAVE_ADDR_IN; // R17
						3'h1: next_byte = r_reg.func | mrf_pkg::EXC_FLAG; // R1
						default: next_byte = r_reg.exc_code; // R1 R17
					endcase
					r_next.tx.valid = 1'b1;
					r_next.tx.data = next_byte;
				end else if (byte_taken && r_reg.idx == 3'h2) begin
					r_next.state = mrf_pkg::MRF_CRC_LO;
				end
			end
			mrf_pkg::MRF_FLOAT: begin
				if (!r_reg.tx.valid && !byte_taken) begin
					r_next.tx.valid = 1'b1;
					r_next.tx.data = float_byte(r_reg.shift, r_reg.idx, FLOAT_SWAP_IN);
				end else if (byte_taken && r_reg.idx == 3'h3) begin
					r_next.state = mrf_pkg::MRF_CRC_LO;
				end
			end
			mrf_pkg::MRF_CRC_LO: begin
				if (!r_reg.tx.valid && !byte_taken) begin
					r_next.tx.valid = 1'b1;
					r_next.tx.data = r_reg.tx_crc[7:0]; // R14 R15
				end else if (byte_taken) begin
					r_next.tx_crc = r_reg.tx_crc; // CRC byte itself is not folded in
					r_next.state = mrf_pkg::MRF_CRC_HI;
				end
			end
			mrf_pkg::MRF_CRC_HI: begin
				if (!r_reg.tx.valid && !byte_taken) begin
					r_next.tx.valid = 1'b1;
					r_next.tx.last = 1'b1;
					r_next.tx.data = r_reg.tx_crc[15:8]; // R15
				end else if (byte_taken) begin
					r_next.state = mrf_pkg::MRF_IDLE;
				end
			end
		endcase
	end

	// Single state register
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r_reg <= '0;
			r_reg.state <= mrf_pkg::MRF_IDLE;
			r_reg.tx_crc <= mrf_pkg::CRC_PRESET;
			r_reg.rx_crc <= mrf_pkg::CRC_PRESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign BUSY_OUT = (r_reg.state != mrf_pkg::MRF_IDLE);
	assign TX_VALID_OUT = r_reg.tx.valid;
	assign TX_DATA_OUT = r_reg.tx.data;
	assign TX_LAST_OUT = r_reg.tx.last;
	assign EXC_CODE_OUT = r_reg.exc_code;
	assign CRC_ERR_OUT = r_reg.crc_err;
	assign CRC_OK_OUT = r_reg.crc_ok;
endmodule

// ---- mrf_chk.sv ----
// Checker of the framer's port timing
`timescale 1ns/1ns
module mrf_chk (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] SLAVE_ADDR_IN,
	input wire logic RX_START_IN,
	input wire logic RX_END_IN,
	input wire logic REQ_IN,
	input wire logic [7:0] REQ_FUNC_IN,
	input wire logic TX_READY_IN,
	input wire logic BUSY_OUT,
	input wire logic TX_VALID_OUT,
	input wire logic [7:0] TX_DATA_OUT,
	input wire logic TX_LAST_OUT,
	input wire logic [7:0] EXC_CODE_OUT,
	input wire logic CRC_ERR_OUT,
	input wire logic CRC_OK_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	logic take;
	// A request counts only while idle
	assign take = REQ_IN && !BUSY_OUT;
	property p_busy; take |=> BUSY_OUT; endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_addr; take |-> ##2 TX_VALID_OUT && TX_DATA_OUT == SLAVE_ADDR_IN; endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_func; take ##2 (TX_VALID_OUT && TX_READY_IN) |->
		##2 TX_VALID_OUT && TX_DATA_OUT == ($past(REQ_FUNC_IN, 4) | 8'h80); endproperty
	a_func: assert property (p_func) else $error("func");
	property p_ill; take && !(REQ_FUNC_IN inside {8'h03, 8'h08, 8'h10}) |-> ##2 EXC_CODE_OUT == 8'h01;
	endproperty
	a_ill: assert property (p_ill) else $error("code");
	property p_hold; TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_gap; TX_VALID_OUT && TX_READY_IN |=> !TX_VALID_OUT; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_last; TX_LAST_OUT |-> TX_VALID_OUT; endproperty
	a_last: assert property (p_last) else $error("last");
	property p_ok; CRC_OK_OUT |-> $past(RX_END_IN) && !CRC_ERR_OUT; endproperty
	a_ok: assert property (p_ok) else $error("ok");
	property p_clr; RX_START_IN |=> !CRC_ERR_OUT && !CRC_OK_OUT; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	c_take: cover property (take);
	c_ok: cover property (CRC_OK_OUT);
	c_err: cover property (CRC_ERR_OUT);
endmodule
bind mrf_framer mrf_chk u_chk (.CLK_IN, .RST_IN, .SLAVE_ADDR_IN, .RX_START_IN, .RX_END_IN, .REQ_IN,
	.REQ_FUNC_IN, .TX_READY_IN, .BUSY_OUT, .TX_VALID_OUT, .TX_DATA_OUT, .TX_LAST_OUT, .EXC_CODE_OUT,
	.CRC_ERR_OUT, .CRC_OK_OUT);

// ---- mrf_master.sv ----
// Serial-line master model that consumes reply bytes
`timescale 1ns/1ns
module mrf_master (
	input wire logic clk_in,
	input wire logic slow_in,
	output logic ready_out
);
	logic ready_reg = 1'b1;
	// A slow master takes every other cycle, so the framer must hold
	always_ff @(posedge clk_in) begin
		ready_reg <= slow_in ? ~ready_reg : 1'b1;
	end
	assign ready_out = ready_reg;
endmodule

// ---- tb_mrf_framer.sv ----
// Self-checking bench for the frame logic
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_mrf_framer;
	typedef struct { logic [7:0] f; logic [2:0] flt; logic [7:0] code; } mrf_row_t;
	logic clk = 1'b0, rst = 1'b1, rxs = 1'b0, rxv = 1'b0, rxe = 1'b0, req = 1'b0, fl = 1'b0;
	logic sw = 1'b0, slow = 1'b0, rdy, busy, tv, tl, err, ok;
	logic [7:0] rxd = 8'h00, func = 8'h00, td, exc, got[$], exp[$];
	logic [31:0] fd = 32'h00000000;
	mrf_pkg::mrf_fault_t flt = 3'b000;
	int mismatches = 0, num_checks = 0;
	// Refusal causes with the code each should give
	mrf_row_t rows[7] = '{'{8'h05, 3'b000, 8'h01}, '{8'h07, 3'b111, 8'h01}, '{8'h03, 3'b110, 8'h02},
		'{8'h08, 3'b011, 8'h03}, '{8'h10, 3'b001, 8'h04}, '{8'h03, 3'b000, 8'h04},
		'{8'h10, 3'b100, 8'h02}};
	always #5 clk = ~clk;
	mrf_framer DUT (.CLK_IN(clk), .RST_IN(rst), .SLAVE_ADDR_IN(8'h11), .RX_START_IN(rxs),
		.RX_VALID_IN(rxv), .RX_DATA_IN(rxd), .RX_END_IN(rxe), .REQ_IN(req), .REQ_FUNC_IN(func),
		.REQ_FAULT_IN(flt), .FLOAT_IN(fl), .FLOAT_DATA_IN(fd), .FLOAT_SWAP_IN(sw), .TX_READY_IN(rdy),
		.BUSY_OUT(busy), .TX_VALID_OUT(tv), .TX_DATA_OUT(td), .TX_LAST_OUT(tl), .EXC_CODE_OUT(exc),
		.CRC_ERR_OUT(err), .CRC_OK_OUT(ok));
	mrf_master u_master (.clk_in(clk), .slow_in(slow), .ready_out(rdy));
	// Bitwise reference, kept apart from any table method
	function automatic logic [15:0] crc16(logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Appends the CRC to the expected bytes and collects the reply
	task automatic send_chk(string n);
		logic [15:0] c;
		int t;
		c = crc16(exp);
		exp.push_back(c[7:0]);
		exp.push_back(c[15:8]);
		got = {};
		t = 0;
		while (got.size() < exp.size() && t < 300) begin
			@(posedge clk);
			t++;
			req <= 1'b0;
			fl <= 1'b0;
			if (tv === 1'b1 && rdy === 1'b1) begin
				got.push_back(td);
				`CHK("last", got.size() == exp.size(), tl)
			end
		end
		if (t >= 300) begin
			mismatches++;
			end_sim();
		end
		foreach (exp[i]) `CHK(n, exp[i], got[i])
	endtask
	// Feeds one received frame, then reads the verdict
	task automatic rx(logic [7:0] q[$], logic good);
		@(posedge clk);
		rxs <= 1'b1;
		foreach (q[i]) begin
			@(posedge clk);
			rxs <= 1'b0;
			rxv <= 1'b1;
			rxd <= q[i];
		end
		@(posedge clk);
		rxv <= 1'b0;
		rxe <= 1'b1;
		@(posedge clk);
		rxe <= 1'b0;
		@(posedge clk);
		`CHK("crc_ok", good, ok)
		`CHK("crc_err", !good, err)
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			func <= rows[i].f;
			flt <= rows[i].flt;
			req <= 1'b1;
			exp = '{8'h11, rows[i].f | 8'h80, rows[i].code};
			send_chk("exc");
			`CHK("exc_code", rows[i].code, exc)
		end
		// Float frames with a stalling master, default then swapped order
		slow <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			fd <= 32'h42C80000;
			sw <= s[0];
			fl <= 1'b1;
			if (s == 0) exp = '{8'h42, 8'hC8, 8'h00, 8'h00};
			else exp = '{8'h00, 8'h00, 8'hC8, 8'h42};
			send_chk("float");
		end
		rx('{8'h01, 8'h03, 8'h0B, 8'hB8, 8'h00, 8'h02, 8'h46, 8'h0A}, 1'b1);
		rx('{8'h01, 8'h03, 8'h0B, 8'hB8, 8'h00, 8'h02, 8'h0A, 8'h46}, 1'b0);
		rx('{8'h01, 8'h03}, 1'b0);
		// Second request while busy carries a fault that would give another code
		@(posedge clk);
		func <= 8'h05;
		flt <= 3'b100;
		req <= 1'b1;
		@(posedge clk);
		func <= 8'h03;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		`CHK("exc_busy", 8'h01, exc)
		`CHK("busy", 1'b1, busy)
		// Reset lands in mid-frame; the stream and the sticky error must clear
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("busy_rst", 1'b0, busy)
		`CHK("valid_rst", 1'b0, tv)
		`CHK("exc_rst", 8'h00, exc)
		`CHK("err_rst", 1'b0, err)
		// A request right after reset still yields a whole frame
		func <= 8'h08;
		flt <= 3'b010;
		req <= 1'b1;
		exp = '{8'h11, 8'h88, 8'h03};
		send_chk("exc_after_rst");
		`CHK("code_after_rst", 8'h03, exc)
		end_sim();
	end
endmodule
